// ==== verification/rps_diag_model.sv ====
`timescale 1ns/100ps
//==============================================================
// diagnostic controller model: owns the diag clock and serial line
module rps_diag_model (
    // link to the device
    output logic diag_shift_clock,
    output logic serial_in
);
    // clock stands low between frames so the shadow never moves unasked
    initial begin
        diag_shift_clock = 1'b0;
        serial_in = 1'b1;
    end

    // one 6 ns frame cycle, serial line set up half a period ahead;
    // runs with no regard to the pipeline clock phase
    task automatic tick(input logic sd);
        serial_in = sd;
        #3 diag_shift_clock = 1'b1;
        #3 diag_shift_clock = 1'b0;
    endtask : tick
endmodule : rps_diag_model

// ==== verification/rps_prom_shadow_tb.sv ====
`timescale 1ns/100ps
//==============================================================
// bench for the registered array with shadow scan
module rps_prom_shadow_tb;
    import rps_pkg::*;
    logic hclk = 1'b0;
    logic hresetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    rps_sys_s sys_pins;
    logic diag_shift_clock;
    logic serial_in;
    logic serial_out;
    logic ext_hold = 1'b0;
    logic [3:0] data_io_i;
    logic [3:0] data_io_o;
    logic [3:0] data_io_oe;
    logic [31:0] rd;
    logic [3:0] pat = 4'hd;
    int miscompares = 0;
    int n_tests = 0;
    int cycles = 0;

    //==============================================================
    // clock, wire level and parts
    always #5 hclk = ~hclk;

    // a released pin toggles every half cycle unless ext_hold sets it to 4'ha, so a stale value cannot pass
    assign data_io_i = data_io_oe[0] ? data_io_o :
        (ext_hold ? 4'ha : {2{hclk, ~hclk}});

    rps_prom_shadow i_rps_prom_shadow (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .sys_pins(sys_pins),
        .diag_shift_clock(diag_shift_clock), .serial_in(serial_in),
        .serial_out(serial_out), .data_io_i(data_io_i),
        .data_io_o(data_io_o), .data_io_oe(data_io_oe)
    );

    rps_diag_model i_rps_diag_model (
        .diag_shift_clock(diag_shift_clock),
        .serial_in(serial_in)
    );

    //==============================================================
    // helpers
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check

    // single word transfer, held until hready is seen high
    task automatic bus(input logic [7:0] a, input logic wr,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        hsize <= 3'h2;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
        check("response", {31'h0, hresp}, 32'h0);
    endtask : bus

    // one pipeline edge, then look at the pins once they settle
    task automatic pipe(input logic [3:0] exp);
        @(posedge hclk);
        #1;
        check("pipeline", {28'h0, data_io_o}, {28'h0, exp});
    endtask : pipe

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test

    // hang guard, far above the 80 or so cycles the tests need
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            stop_test();
        end
    end

    //==============================================================
    // test sequence
    initial begin
        // idle bus; initialize held low so the unfilled array is never read
        hresetn <= 1'b0;
        hsel <= 1'b0;
        haddr <= 32'h0;
        htrans <= 2'h0;
        hwrite <= 1'b0;
        hsize <= 3'h2;
        hwdata <= 32'h0;
        sys_pins <= '{11'h000, 1'b0, 1'b0, 1'b0};
        // diag side needs its own edges to leave reset
        for (int i = 0; i < 3; i++) i_rps_diag_model.tick(1'b0);
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        i_rps_diag_model.tick(1'b0);
        i_rps_diag_model.tick(1'b0);
        bus(RPS_OFF_ARCH, 1'b0, 32'h0, rd);
        check("arch reset", rd, 32'h0);
        bus(RPS_OFF_INIT, 1'b0, 32'h0, rd);
        check("init reset", rd, 32'h0);
        bus(8'h20, 1'b1, 32'hffff_ffff, rd);
        bus(8'h20, 1'b0, 32'h0, rd);
        check("unmapped", rd, 32'h0);
        $display("test registers done");

        // fill the top two words, then leave initialize
        bus(RPS_OFF_PADDR, 1'b1, 32'h7fe, rd);
        bus(RPS_OFF_PDATA, 1'b1, 32'h5, rd);
        bus(RPS_OFF_PDATA, 1'b1, 32'h9, rd);
        bus(RPS_OFF_INIT, 1'b1, 32'hc, rd);
        @(posedge hclk);
        sys_pins.addr <= 11'h7ff;
        sys_pins.init_n <= 1'b1;
        pipe(4'h9);
        check("enable", {28'h0, data_io_oe}, 32'hf);
        sys_pins.addr <= 11'h7fe;
        pipe(4'h5);
        $display("test array read done");

        // async enable and initialize act with no clock edge
        sys_pins.out_enable_n <= 1'b1;
        sys_pins.init_n <= 1'b0;
        #1;
        check("async enable", {28'h0, data_io_oe}, 32'h0);
        check("async init", {28'h0, data_io_o}, 32'hc);
        pipe(4'hc);
        pipe(4'hc);
        sys_pins.init_n <= 1'b1;
        sys_pins.out_enable_n <= 1'b0;
        pipe(4'h5);
        $display("test async controls done");

        // synchronous enable and initialize wait for the edge
        bus(RPS_OFF_ARCH, 1'b1, 32'h3, rd);
        sys_pins.out_enable_n <= 1'b1;
        sys_pins.init_n <= 1'b0;
        #1;
        check("sync enable held", {28'h0, data_io_oe}, 32'hf);
        check("sync init held", {28'h0, data_io_o}, 32'h5);
        pipe(4'hc);
        check("sync enable off", {28'h0, data_io_oe}, 32'h0);
        sys_pins.init_n <= 1'b1;
        $display("test sync controls done");

        // shift a pattern through and out of the shadow
        for (int i = 0; i < 8; i++) begin
            i_rps_diag_model.tick(i < 4 ? pat[i] : 1'b0);
            #1;
            check("serial out", {31'h0, serial_out},
                  {31'h0, (i >= 3 && i < 7) ? pat[i - 3] : 1'b0});
        end
        for (int i = 0; i < 4; i++) i_rps_diag_model.tick(pat[i]);
        $display("test shift done");

        // mode high: pass-through, hold, copy into the pipeline
        @(posedge hclk);
        sys_pins.mode <= 1'b1;
        #1;
        check("pass high", {31'h0, serial_out}, 32'h1);
        // spare no-op edges let the last shadow word cross to hclk
        repeat (8) i_rps_diag_model.tick(1'b1);
        i_rps_diag_model.serial_in = 1'b0;
        #1;
        check("pass low", {31'h0, serial_out}, 32'h0);
        i_rps_diag_model.serial_in = 1'b1;
        repeat (8) @(posedge hclk);
        pipe(4'hb);
        bus(RPS_OFF_STATUS, 1'b0, 32'h0, rd);
        check("mirror", {28'h0, rd[7:4]}, 32'hb);
        $display("test shadow to pipeline done");

        // parallel capture from the released pins
        ext_hold = 1'b1;
        i_rps_diag_model.tick(1'b0);
        repeat (3) i_rps_diag_model.tick(1'b1);
        repeat (8) @(posedge hclk);
        pipe(4'ha);
        sys_pins.mode <= 1'b0;
        #1;
        check("stage three", {31'h0, serial_out}, 32'h1);
        i_rps_diag_model.tick(1'b0);
        #1;
        check("shift after load", {31'h0, serial_out}, 32'h0);
        $display("test capture done");
        stop_test();
    end
endmodule : rps_prom_shadow_tb

// ==== verilog/rps_pkg.sv ====
//==============================================================
// shared constants and carriers
package rps_pkg;

    // array geometry
    localparam int unsigned RPS_ADDR_W = 11;
    localparam int unsigned RPS_WORD_W = 4;
    localparam int unsigned RPS_WORDS = 2048;

    // register byte offsets
    localparam logic [7:0] RPS_OFF_ARCH = 8'h00;
    localparam logic [7:0] RPS_OFF_INIT = 8'h04;
    localparam logic [7:0] RPS_OFF_PADDR = 8'h08;
    localparam logic [7:0] RPS_OFF_PDATA = 8'h0c;
    localparam logic [7:0] RPS_OFF_STATUS = 8'h10;

    // field positions
    localparam int unsigned RPS_ARCH_SOE_BIT = 0;
    localparam int unsigned RPS_ARCH_SINIT_BIT = 1;
    localparam int unsigned RPS_ST_PIPE_LSB = 0;
    localparam int unsigned RPS_ST_MIRROR_LSB = 4;
    localparam int unsigned RPS_ST_OE_BIT = 8;
    localparam int unsigned RPS_ST_MODE_BIT = 9;

    // values after reset (unprogrammed architecture is asynchronous)
    localparam logic [1:0] RPS_ARCH_RST = 2'h0;
    localparam logic [3:0] RPS_INIT_RST = 4'h0;
    localparam logic [3:0] RPS_PIPE_RST = 4'h0;
    localparam logic [3:0] RPS_SHADOW_RST = 4'h0;
    localparam logic [10:0] RPS_PADDR_RST = 11'h000;

    // ahb transfer type bit that marks an active transfer
    localparam int unsigned RPS_HTRANS_ACT_BIT = 1;

    // system sequencer pins, sampled on the pipeline clock; async controls act at once, mode also on the diag clock
    typedef struct packed {
        logic [10:0] addr;
        logic mode;
        logic out_enable_n;
        logic init_n;
    } rps_sys_s;

    // architecture word
    typedef struct packed {
        logic sync_init;
        logic sync_out_enable;
    } rps_arch_s;

endpackage : rps_pkg

// ==== verilog/rps_prom_shadow.sv ====
// The AHB-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
//==============================================================
module rps_prom_shadow (
    // ahb-lite slave, hclk is also the pipeline clock
    input logic hclk,
    input logic hresetn,
    input logic hsel,
    input logic [31:0] haddr,
    input logic [1:0] htrans,
    input logic hwrite,
    input logic [2:0] hsize,
    input logic [31:0] hwdata,
    input logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // system sequencer pins
    input rps_pkg::rps_sys_s sys_pins,
    // diagnostic link
    input logic diag_shift_clock,
    input logic serial_in,
    output logic serial_out,
    // data pins, three signals per two-way pin
    input logic [3:0] data_io_i,
    output logic [3:0] data_io_o,
    output logic [3:0] data_io_oe
);
    import rps_pkg::*;

    // byte offset of a bus address, zero-extended page above is unmapped
    function automatic logic [8:0] bus_off(input logic [31:0] a);
        bus_off = {(a[31:8] != 24'h000000), a[7:0]};
    endfunction : bus_off

    //==========================================================
    // register state
    rps_arch_s arch_q;
    logic [3:0] init_word_q;
    logic [10:0] prog_addr_q;
    logic [3:0] rom_mem [0:RPS_WORDS-1];
    logic [3:0] pipeline_bits_q;
    logic [3:0] mirror_q;
    logic oe_q;
    logic wr_pend_q;
    logic [8:0] wr_off_q;
    logic [31:0] hrdata_q;
    logic [3:0] rom_word;
    logic async_init;
    logic ap_take;

    // diag domain state
    logic diag_rst_s1_q;
    logic diag_rst_n_q;
    logic [3:0] shadow_stages_q;
    logic [3:0] xfer_word_q;
    logic xfer_req_q;
    logic ack_s1_q;
    logic ack_s2_q;

    // hclk side of the crossing
    logic req_s1_q;
    logic req_s2_q;
    logic req_s3_q;
    logic ack_q;

    //==========================================================
    // ahb-lite slave: zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign ap_take = hsel & htrans[RPS_HTRANS_ACT_BIT] & hready;

    // address phase capture; reads are answered from a flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_off_q <= 9'h000;
            hrdata_q <= 32'h00000000;
        end else begin
            wr_pend_q <= ap_take & hwrite;
            wr_off_q <= bus_off(haddr);
            if (ap_take && !hwrite) begin
                case (bus_off(haddr))
                    {1'b0, RPS_OFF_ARCH}: begin
                        hrdata_q <= {30'h00000000, arch_q};
                    end
                    {1'b0, RPS_OFF_INIT}: begin
                        hrdata_q <= {28'h0000000, init_word_q};
                    end
                    {1'b0, RPS_OFF_PADDR}: begin
                        hrdata_q <= {21'h000000, prog_addr_q};
                    end
                    {1'b0, RPS_OFF_PDATA}: begin
                        hrdata_q <= {28'h0000000, rom_mem[prog_addr_q]};
                    end
                    {1'b0, RPS_OFF_STATUS}: begin
                        hrdata_q <= {22'h000000, sys_pins.mode,
                            data_io_oe[0], mirror_q, data_io_o};
                    end
                    default: begin
                        hrdata_q <= 32'h00000000; // unmapped reads zero
                    end
                endcase
            end
        end
    end

    // register writes in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            arch_q <= RPS_ARCH_RST;
            init_word_q <= RPS_INIT_RST;
            prog_addr_q <= RPS_PADDR_RST;
        end else if (wr_pend_q) begin
            case (wr_off_q)
                {1'b0, RPS_OFF_ARCH}: begin
                    arch_q <= hwdata[1:0];
                end
                {1'b0, RPS_OFF_INIT}: begin
                    init_word_q <= hwdata[3:0];
                end
                {1'b0, RPS_OFF_PADDR}: begin
                    prog_addr_q <= hwdata[10:0];
                end
                {1'b0, RPS_OFF_PDATA}: begin
                    prog_addr_q <= prog_addr_q + 11'h001; // burst fill
                end
                default: begin
                    prog_addr_q <= prog_addr_q;
                end
            endcase
        end
    end

    // array fill port; memory has no reset, contents are loaded by sw
    always_ff @(posedge hclk) begin
        if (wr_pend_q && wr_off_q == {1'b0, RPS_OFF_PDATA}) begin
            rom_mem[prog_addr_q] <= hwdata[3:0];
        end
    end

    //==========================================================
    // pipeline register on the pipeline clock
    assign rom_word = rom_mem[sys_pins.addr];
    assign async_init = !arch_q.sync_init && !sys_pins.init_n;

    // source priority: held async init, then mode, then sync init
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pipeline_bits_q <= RPS_PIPE_RST;
        end else if (async_init) begin
            pipeline_bits_q <= init_word_q;
        end else if (sys_pins.mode) begin
            pipeline_bits_q <= mirror_q;
        end else if (arch_q.sync_init && !sys_pins.init_n) begin
            pipeline_bits_q <= init_word_q;
        end else begin
            pipeline_bits_q <= rom_word;
        end
    end

    // synchronous enable sample for the data pin enables
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            oe_q <= 1'b0;
        end else begin
            oe_q <= !sys_pins.out_enable_n;
        end
    end

    // async initialize shows at the pins without waiting for a clock
    // edge; the flop follows on the next edge and stays there
    assign data_io_o = async_init ? init_word_q : pipeline_bits_q;
    assign data_io_oe = arch_q.sync_out_enable ? {4{oe_q}}
        : {4{!sys_pins.out_enable_n}};

    //==========================================================
    // diag domain reset: asserted at once, released on its own clock
    always_ff @(posedge diag_shift_clock or negedge hresetn) begin
        if (!hresetn) begin
            diag_rst_s1_q <= 1'b0;
            diag_rst_n_q <= 1'b0;
        end else begin
            diag_rst_s1_q <= 1'b1;
            diag_rst_n_q <= diag_rst_s1_q;
        end
    end

    // shadow register: shift, parallel load from pins, or hold
    always_ff @(posedge diag_shift_clock or negedge diag_rst_n_q) begin
        if (!diag_rst_n_q) begin
            shadow_stages_q <= RPS_SHADOW_RST;
        end else if (!sys_pins.mode) begin
            shadow_stages_q <= {shadow_stages_q[2:0], serial_in};
        end else if (!serial_in) begin
            shadow_stages_q <= data_io_i;
        end else begin
            shadow_stages_q <= shadow_stages_q;
        end
    end

    // serial out is a pass-through of the control in mode high
    assign serial_out = sys_pins.mode ? serial_in
        : shadow_stages_q[3];

    //==========================================================
    // shadow word to hclk: toggle handshake, word stable while pending.
    // a new change is sent only once the previous one is acknowledged,
    // so diag edges must go on after the last shadow change until the ack returns
    always_ff @(posedge diag_shift_clock or negedge diag_rst_n_q) begin
        if (!diag_rst_n_q) begin
            xfer_word_q <= RPS_SHADOW_RST;
            xfer_req_q <= 1'b0;
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
        end else begin
            ack_s1_q <= ack_q;
            ack_s2_q <= ack_s1_q;
            if (xfer_req_q == ack_s2_q && xfer_word_q != shadow_stages_q)
            begin
                xfer_word_q <= shadow_stages_q;
                xfer_req_q <= !xfer_req_q;
            end
        end
    end

    // hclk side: sync request, take word on its toggle, echo as ack
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
            req_s3_q <= 1'b0;
            ack_q <= 1'b0;
            mirror_q <= RPS_SHADOW_RST;
        end else begin
            req_s1_q <= xfer_req_q;
            req_s2_q <= req_s1_q;
            req_s3_q <= req_s2_q;
            ack_q <= req_s2_q;
            if (req_s2_q != req_s3_q) begin
                mirror_q <= xfer_word_q;
            end
        end
    end

    //==========================================================
    // checks on the pipeline clock
    pipe_array_load_a:
    assert property (@(posedge hclk) disable iff (!hresetn)
        !sys_pins.mode && sys_pins.init_n
        |=> pipeline_bits_q == $past(rom_word))
    else $error("pipeline did not take the addressed array word");

    pipe_shadow_copy_a:
    assert property (@(posedge hclk) disable iff (!hresetn)
        sys_pins.mode && !async_init
        |=> pipeline_bits_q == $past(mirror_q))
    else $error("pipeline did not copy the shadow word");

    sync_init_load_a:
    assert property (@(posedge hclk) disable iff (!hresetn)
        !sys_pins.mode && arch_q.sync_init && !sys_pins.init_n
        |=> pipeline_bits_q == $past(init_word_q))
    else $error("sync initialize did not load the word");

    async_init_hold_a:
    assert property (@(posedge hclk) disable iff (!hresetn)
        async_init [*2] |-> pipeline_bits_q == $past(init_word_q)
            && data_io_o == init_word_q)
    else $error("async initialize not holding the word");

    sync_oe_track_a:
    assert property (@(posedge hclk) disable iff (!hresetn)
        arch_q.sync_out_enable ##1 arch_q.sync_out_enable
        |-> data_io_oe == {4{!$past(sys_pins.out_enable_n)}})
    else $error("sync enable not applied on the clock edge");

    async_oe_direct_a:
    assert property (@(posedge hclk) disable iff (!hresetn)
        !arch_q.sync_out_enable
        |-> data_io_oe == {4{!sys_pins.out_enable_n}})
    else $error("async enable not driving the outputs directly");

    mirror_follow_a:
    assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(req_s2_q) or $fell(req_s2_q)
        |=> mirror_q == $past(xfer_word_q))
    else $error("shadow mirror missed a handshake");

    // checks on the diagnostic clock
    shadow_shift_a:
    assert property (@(posedge diag_shift_clock) disable iff (!diag_rst_n_q)
        !sys_pins.mode |=> shadow_stages_q
            == {$past(shadow_stages_q[2:0]), $past(serial_in)})
    else $error("shadow did not shift one place");

    shadow_par_load_a:
    assert property (@(posedge diag_shift_clock) disable iff (!diag_rst_n_q)
        sys_pins.mode && !serial_in
        |=> shadow_stages_q == $past(data_io_i))
    else $error("shadow did not load the data pins");

    shadow_noop_a:
    assert property (@(posedge diag_shift_clock) disable iff (!diag_rst_n_q)
        sys_pins.mode && serial_in |=> $stable(shadow_stages_q))
    else $error("shadow changed on a no-op");

    serial_out_mux_a:
    assert property (@(posedge diag_shift_clock) disable iff (!diag_rst_n_q)
        serial_out == (sys_pins.mode ? serial_in : shadow_stages_q[3]))
    else $error("serial out shows the wrong source");

    // main scenarios
    shift_four_c: cover property (@(posedge diag_shift_clock)
        disable iff (!diag_rst_n_q) !sys_pins.mode [*4]);
    shadow_to_pipe_c: cover property (@(posedge hclk)
        disable iff (!hresetn) sys_pins.mode && mirror_q != 4'h0);
    sync_init_c: cover property (@(posedge hclk)
        disable iff (!hresetn) arch_q.sync_init && !sys_pins.init_n);
    async_init_c: cover property (@(posedge hclk)
        disable iff (!hresetn) async_init);

endmodule : rps_prom_shadow
